/* File: brc_checker.sv */
// Purpose: Port-level assertions for the clock/calendar block
// Assumes: Only top ports visible; index, control and locks shadowed here
// Notes: Lead check assumes software never sets SET while UPDATE_IN_PROGRESS_FLAG is high
`timescale 1ns/1ps
`default_nettype none
module brc_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Inputs
   input wire logic osc_32k,
   input wire logic [1:0] host_sel,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [7:0] host_wdata,
   input wire logic lock0_set,
   input wire logic lock1_set,
   input wire logic in_working,
   input wire logic century_clr,
   // Outputs
   input wire logic [7:0] host_rdata,
   input wire logic update_in_progress_flag,
   input wire logic clock_interrupt_line,
   input wire logic century_rollover_flag,
   input wire logic system_mgmt_interrupt
);
   logic [6:0] idx0_q, idx1_q;
   logic [7:0] ctl_b_q, ocnt_q;
   logic lk0_q, lk1_q, osc_q, uip_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         idx0_q <= 7'h00;
         idx1_q <= 7'h00;
         ctl_b_q <= 8'h02;
         ocnt_q <= 8'h00;
         lk0_q <= 1'b0;
         lk1_q <= 1'b0;
         osc_q <= 1'b0;
         uip_q <= 1'b0;
      end else begin
         osc_q <= osc_32k;
         uip_q <= update_in_progress_flag;
         if (host_wr && host_sel == 2'h0) idx0_q <= host_wdata[6:0];
         if (host_wr && host_sel == 2'h2) idx1_q <= host_wdata[6:0];
         if (host_wr && host_sel == 2'h1 && idx0_q == 7'h0B) ctl_b_q <= host_wdata;
         if (lock0_set) lk0_q <= 1'b1;
         if (lock1_set) lk1_q <= 1'b1;
         // Raw pin edges: sync delay shifts both ends of the window alike
         if (update_in_progress_flag && !uip_q) ocnt_q <= 8'h00;
         else if (update_in_progress_flag && osc_32k && !osc_q) ocnt_q <= ocnt_q + 8'h01;
      end
   end
   sequence s_uip_end;
      $fell(update_in_progress_flag);
   endsequence
   sequence s_lock_lo_rd;
      host_rd && host_sel == 2'h1 && lk0_q && idx0_q[6:3] == 4'h7;
   endsequence
   sequence s_lock_hi_rd;
      host_rd && host_sel == 2'h3 && lk1_q && idx1_q[6:3] == 4'h7;
   endsequence
   a_idx_read: assert property (host_rd && host_sel == 2'h0 && !host_wr
      |=> host_rdata == {1'b0, $past(idx0_q)}) else $error("index read mismatch");
   a_stat_d: assert property (host_rd && host_sel == 2'h1 && idx0_q == 7'h0D
      |=> host_rdata == 8'h80) else $error("register D read mismatch");
   a_lock_lo: assert property (s_lock_lo_rd |=> host_rdata == 8'h00)
      else $error("locked lower range leaked data");
   a_lock_hi: assert property (s_lock_hi_rd |=> host_rdata == 8'h00)
      else $error("locked upper range leaked data");
   a_irq_enable: assert property ($rose(clock_interrupt_line)
      |-> ((ctl_b_q | $past(ctl_b_q)) & 8'h70) != 8'h00) else $error("irq while disabled");
   a_uip_lead: assert property (s_uip_end |-> ocnt_q >= 8'h10)
      else $error("update began too soon after UPDATE_IN_PROGRESS_FLAG");
   a_uip_max: assert property (update_in_progress_flag |-> ocnt_q <= 8'h41)
      else $error("update cycle too long");
   a_cent_sticky: assert property (century_rollover_flag && !century_clr
      |=> century_rollover_flag) else $error("century flag lost");
   a_cent_update: assert property ($rose(century_rollover_flag)
      |-> update_in_progress_flag || $past(update_in_progress_flag))
      else $error("century flag outside update");
   a_smi_flag: assert property (system_mgmt_interrupt |-> century_rollover_flag)
      else $error("smi without century flag");
   a_smi_pulse: assert property (system_mgmt_interrupt |=> !system_mgmt_interrupt)
      else $error("smi longer than one cycle");
   a_smi_sleep: assert property ((!in_working) [*2] |-> !system_mgmt_interrupt)
      else $error("smi in sleep state");
endmodule
bind brc_top brc_checker i_brc_checker (.clk(clk), .rst_n(rst_n), .osc_32k(osc_32k),
   .host_sel(host_sel), .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
   .lock0_set(lock0_set), .lock1_set(lock1_set), .in_working(in_working),
   .century_clr(century_clr), .host_rdata(host_rdata),
   .update_in_progress_flag(update_in_progress_flag),
   .clock_interrupt_line(clock_interrupt_line),
   .century_rollover_flag(century_rollover_flag),
   .system_mgmt_interrupt(system_mgmt_interrupt));
`default_nettype wire

/* File: brc_inc.v */
// Purpose: Increment one calendar field with wrap, in BCD or binary form
// Assumes: Value lies within lo..hi; lo and hi given in binary
// Notes: Shared by all fields of the update sequence except day of week, which steps on its own
`timescale 1ns/1ps
`default_nettype none
module brc_inc (
   // Field
   input wire [7:0] val,
   input wire [7:0] lo,
   input wire [7:0] hi,
   input wire bin_mode,
   // Result
   output wire [7:0] nxt,
   output wire [7:0] nxt_bin,
   output wire wrap
);
   wire [7:0] cur_bin;
   wire [7:0] sum;
   wire [7:0] tens;
   wire [7:0] ones;

   assign cur_bin = bin_mode ? val : ((val[7:4] * 8'h0A) + {4'h0, val[3:0]});
   assign wrap = (cur_bin >= hi);
   assign sum = cur_bin + 8'h01;
   assign nxt_bin = wrap ? lo : sum;
   // Tens digit never exceeds 9 for calendar ranges
   assign tens = nxt_bin / 8'h0A;
   assign ones = nxt_bin % 8'h0A;
   assign nxt = bin_mode ? nxt_bin : {tens[3:0], ones[3:0]};
endmodule
`default_nettype wire

/* File: brc_map.vh */
// Purpose: Constants for the battery-backed clock/calendar block
// Assumes: Included by bare name from the top design file only
// Notes: Definitions only
`ifndef BRC_MAP_VH
`define BRC_MAP_VH
`define BRC_IDX_SEC 7'h00
`define BRC_IDX_ASEC 7'h01
`define BRC_IDX_MIN 7'h02
`define BRC_IDX_AMIN 7'h03
`define BRC_IDX_HR 7'h04
`define BRC_IDX_AHR 7'h05
`define BRC_IDX_DOW 7'h06
`define BRC_IDX_DATE 7'h07
`define BRC_IDX_MON 7'h08
`define BRC_IDX_YEAR 7'h09
`define BRC_IDX_A 7'h0A
`define BRC_IDX_B 7'h0B
`define BRC_IDX_C 7'h0C
`define BRC_IDX_D 7'h0D
`define BRC_TM_LAST 7'h09
`define BRC_A_UIP 7
`define BRC_B_SET 7
`define BRC_B_PIE 6
`define BRC_B_AIE 5
`define BRC_B_UIE 4
`define BRC_B_DM 2
`define BRC_B_H24 1
`define BRC_B_DSE 0
`define BRC_C_IRQF 7
`define BRC_C_PF 6
`define BRC_C_AF 5
`define BRC_C_UF 4
`define BRC_D_VRT 8'h80
`define BRC_A_RST 8'h00
`define BRC_B_RST 8'h02
`define BRC_DIV_OK 3'h2
`define BRC_DIV_TOP 15'h7FFF
`define BRC_OSC_HZ 32768
`define BRC_UIP_LEAD_US 488
`define BRC_UIP_LEAD_TICKS ((`BRC_UIP_LEAD_US*`BRC_OSC_HZ+999999)/1000000)
`define BRC_ALM_DC 2'h3
`define BRC_LOCK_BLK 4'h7
`define BRC_LOCKED_RD 8'h00
`define BRC_PM_BIT 7
`define BRC_DST_APR_DATE 8'h18
`define BRC_DST_OCT_DATE 8'h19
`endif

/* File: brc_ram.v */
// Purpose: Battery-backed byte store, two banks of 128 bytes
// Assumes: Bank in address bit 7, write takes effect at the clock edge
// Notes: Contents are not cleared by reset, as a battery store would keep them
`timescale 1ns/1ps
`default_nettype none
module brc_ram (
   // Clock
   input wire clk,
   // Access
   input wire [7:0] addr,
   input wire wr_en,
   input wire [7:0] wdata,
   output wire [7:0] rdata
);
   reg [7:0] mem [0:255];

   always @(posedge clk) begin
      if (wr_en) begin
         mem[addr] <= wdata;
      end
   end

   assign rdata = mem[addr];
endmodule
`default_nettype wire

/* File: brc_sys_model.sv */
// Purpose: Far side model: oscillator pin and system interrupt logic
// Assumes: Driven from the bench clock, changes just after each rising edge
// Notes: Oscillator runs at half the clock so that one second fits the run
`timescale 1ns/1ps
`default_nettype none
module brc_sys_model (
   // Clock
   input wire logic clk,
   // Oscillator pin
   output logic osc_32k,
   // System management interrupt
   input wire logic system_mgmt_interrupt,
   output logic [7:0] smi_count_q
);
   initial begin
      osc_32k = 1'b0;
      smi_count_q = 8'h00;
   end
   // Fast timebase, still two clocks per period for the synchroniser
   always @(posedge clk) begin
      osc_32k <= !osc_32k;
   end
   // Counts pulses, a level stuck high counts many times
   always @(posedge clk) begin
      if (system_mgmt_interrupt === 1'b1) begin
         smi_count_q <= smi_count_q + 8'h01;
      end
   end
endmodule
`default_nettype wire

/* File: brc_top.v */
// Purpose: Clock/calendar with alarm, periodic and update interrupts, locks
// Assumes: Host reaches bytes by an index port and a data port per bank
// Notes: Oscillator pin is sampled on clk, so clk must be well above 32.768 kHz
//
// Contract
// - Two 128-byte battery RAM banks; 114 general bytes in the first.
// - Alarm, periodic 122 us to 500 ms, and update-ended interrupt sources.
// - Count seconds to year, 12/24 hour form, BCD or binary values.
// - Daylight-savings adjustment is optional and selectable.
// - Once-per-second update derived from 32.768 kHz through a divider.
// - Bytes 0-9 hold time and date; 0Ah-0Dh are control and status.
// - Alarm byte C0-FFh is a wildcard matching every field value.
// - Alarm flag needs all fields matching; interrupt only when enabled.
// - During update, time bytes may read stale; writes are discarded.
// - No month or year alarm matching.
// - Each second, unless inhibited or misconfigured, increment, check, write back.
// - Update starts at least 488 us after UPDATE_IN_PROGRESS_FLAG, ends within 1984 us.
// - Time and date bytes 0-9 isolated from host during update.
// - Interrupt goes internally on line 8, unshared, never off-chip.
// - Clock frame in serial interrupt stream is ignored.
// - Two lockable 8-byte ranges; locked writes do nothing, reads differ.
// - A locked range stays locked until hard reset.
// - Year 99 to 00 sets century-rollover flag at bit 7.
// - Century rollover raises SMI only in working state, never in sleep.
`include "brc_map.vh"
`timescale 1ns/1ps
`default_nettype none
module brc_top (
   // Clock and hard reset
   input wire clk,
   input wire rst_n,
   // Oscillator pin
   input wire osc_32k,
   // Indexed host access: 0 index lo, 1 data lo, 2 index hi, 3 data hi
   input wire [1:0] host_sel,
   input wire host_wr,
   input wire host_rd,
   input wire [7:0] host_wdata,
   output reg [7:0] host_rdata,
   // Range locks, power state and century flag clear
   input wire lock0_set,
   input wire lock1_set,
   input wire in_working,
   input wire century_clr,
   // Status and interrupts
   output reg update_in_progress_flag,
   output reg clock_interrupt_line,
   output reg century_rollover_flag,
   output reg system_mgmt_interrupt
);
   localparam ST_IDLE = 3'h0;
   localparam ST_SEC = 3'h1;
   localparam ST_MIN = 3'h2;
   localparam ST_HR = 3'h3;
   localparam ST_DAY = 3'h4;
   localparam ST_MON = 3'h5;
   localparam ST_YR = 3'h6;
   localparam ST_ALM = 3'h7;
   localparam integer UIP_LEAD = `BRC_UIP_LEAD_TICKS;

   reg [7:0] tm_q [0:9];
   reg [7:0] a_q;
   reg [7:0] b_q;
   reg [3:0] c_q;
   reg [6:0] idx_lo_q;
   reg [6:0] idx_hi_q;
   reg [2:0] st_q;
   reg [14:0] div_q;
   reg osc_s1_q;
   reg osc_s2_q;
   reg osc_s3_q;
   reg lock0_q;
   reg lock1_q;
   reg fall_done_q;
   reg pf_set;
   reg [7:0] inc_val;
   reg [7:0] inc_lo;
   reg [7:0] inc_hi;
   reg [7:0] rd_d;
   reg [3:0] c_d;
   reg [3:0] per_exp;
   wire [7:0] inc_nxt;
   wire [7:0] inc_nxt_bin;
   wire inc_wrap;
   wire [7:0] ram_rdata;
   wire tick;
   wire [14:0] div_nxt;
   wire [14:0] uip_at;
   wire [14:0] per_mask;
   wire sec_tick;
   wire busy;
   wire bin;
   wire h24;
   wire [6:0] acc_idx;
   wire acc_hi;
   wire data_acc;
   wire acc_locked;
   wire acc_tm;
   wire acc_ctl;
   wire host_wr_data;
   wire ram_wr;
   wire [7:0] mon_b;
   wire [7:0] date_b;
   wire [7:0] yr_b;
   wire [7:0] hr_b;
   wire [7:0] mdays;
   wire alm_hit;
   wire uf_set;
   wire af_set;
   wire c_clr;

   function [7:0] to_bin;
      input [7:0] v;
      input m;
      begin
         to_bin = m ? v : ((v[7:4] * 8'h0A) + {4'h0, v[3:0]});
      end
   endfunction

   // Alarm byte wildcard or equal
   function fld_match;
      input [7:0] alm;
      input [7:0] cur;
      begin
         fld_match = (alm[7:6] == `BRC_ALM_DC) || (alm == cur);
      end
   endfunction

   // Oscillator pin synchroniser and edge detect
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_s1_q <= 1'b0;
         osc_s2_q <= 1'b0;
         osc_s3_q <= 1'b0;
      end else begin
         osc_s1_q <= osc_32k;
         osc_s2_q <= osc_s1_q;
         osc_s3_q <= osc_s2_q;
      end
   end
   assign tick = osc_s2_q & ~osc_s3_q;

   assign div_nxt = div_q + 15'h0001;
   // Cut to divider width; a bare 32-bit lead would never match the count
   assign uip_at = 15'h0000 - UIP_LEAD[14:0];
   assign sec_tick = tick && (div_q == `BRC_DIV_TOP);
   assign bin = b_q[`BRC_B_DM];
   assign h24 = b_q[`BRC_B_H24];
   assign busy = (st_q != ST_IDLE);

   // Rate 1,2 give 128/256 ticks; 3..15 give 4 ticks (122 us) to 16384 (500 ms)
   always @* begin
      if (a_q[3:0] <= 4'h2) begin
         per_exp = a_q[3:0] + 4'h6;
      end else begin
         per_exp = a_q[3:0] - 4'h1;
      end
   end
   assign per_mask = ~(15'h7FFF << per_exp);
   always @* begin
      pf_set = tick && (a_q[3:0] != 4'h0) && ((div_nxt & per_mask) == 15'h0000);
   end

   // Host address decode
   assign acc_hi = host_sel[1];
   assign acc_idx = acc_hi ? idx_hi_q : idx_lo_q;
   assign data_acc = host_sel[0];
   assign acc_locked = (acc_idx[6:3] == `BRC_LOCK_BLK) && (acc_hi ? lock1_q : lock0_q);
   assign acc_tm = !acc_hi && (acc_idx <= `BRC_TM_LAST);
   assign acc_ctl = !acc_hi && (acc_idx >= `BRC_IDX_A) && (acc_idx <= `BRC_IDX_D);
   assign host_wr_data = host_wr && data_acc;
   assign ram_wr = host_wr_data && !acc_tm && !acc_ctl && !acc_locked;
   assign c_clr = host_rd && data_acc && !acc_hi && (acc_idx == `BRC_IDX_C);

   brc_ram u_ram (
      .clk(clk),
      .addr({acc_hi, acc_idx}),
      .wr_en(ram_wr),
      .wdata(host_wdata),
      .rdata(ram_rdata)
   );

   // Calendar values in binary for limits and DST tests
   assign mon_b = to_bin(tm_q[8], bin);
   assign date_b = to_bin(tm_q[7], bin);
   assign yr_b = to_bin(tm_q[9], bin);
   assign hr_b = to_bin({1'b0, tm_q[4][6:0]}, bin);
   assign mdays = (mon_b == 8'h02) ? ((yr_b[1:0] == 2'h0) ? 8'h1D : 8'h1C) :
                  ((mon_b == 8'h04) || (mon_b == 8'h06) || (mon_b == 8'h09) ||
                   (mon_b == 8'h0B)) ? 8'h1E : 8'h1F;

   // Shared incrementer input per update step
   always @* begin
      inc_val = tm_q[0];
      inc_lo = 8'h00;
      inc_hi = 8'h3B;
      case (st_q)
         ST_MIN: begin
            inc_val = tm_q[2];
         end
         ST_HR: begin
            inc_val = h24 ? tm_q[4] : {1'b0, tm_q[4][6:0]};
            inc_lo = h24 ? 8'h00 : 8'h01;
            inc_hi = h24 ? 8'h17 : 8'h0C;
         end
         ST_DAY: begin
            inc_val = tm_q[7];
            inc_lo = 8'h01;
            inc_hi = mdays;
         end
         ST_MON: begin
            inc_val = tm_q[8];
            inc_lo = 8'h01;
            inc_hi = 8'h0C;
         end
         ST_YR: begin
            inc_val = tm_q[9];
            inc_hi = 8'h63;
         end
         default: begin
            inc_val = tm_q[0];
         end
      endcase
   end

   brc_inc u_inc (
      .val(inc_val),
      .lo(inc_lo),
      .hi(inc_hi),
      .bin_mode(bin),
      .nxt(inc_nxt),
      .nxt_bin(inc_nxt_bin),
      .wrap(inc_wrap)
   );

   // Month and year bytes take no part in the match
   assign alm_hit = fld_match(tm_q[1], tm_q[0]) && fld_match(tm_q[3], tm_q[2]) &&
                    fld_match(tm_q[5], tm_q[4]);
   assign af_set = (st_q == ST_ALM) && alm_hit;
   assign uf_set = (st_q == ST_ALM);

   // Flags: a set in the read-clear cycle wins
   always @* begin
      c_d = c_clr ? 4'h0 : c_q;
      if (pf_set) begin
         c_d[2] = 1'b1;
      end
      if (af_set) begin
         c_d[1] = 1'b1;
      end
      if (uf_set) begin
         c_d[0] = 1'b1;
      end
   end

   // Update sequencer, divider and byte registers
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= ST_IDLE;
         div_q <= 15'h0000;
         a_q <= `BRC_A_RST;
         b_q <= `BRC_B_RST;
         c_q <= 4'h0;
         idx_lo_q <= 7'h00;
         idx_hi_q <= 7'h00;
         fall_done_q <= 1'b0;
         tm_q[0] <= 8'h00;
         tm_q[1] <= 8'h00;
         tm_q[2] <= 8'h00;
         tm_q[3] <= 8'h00;
         tm_q[4] <= 8'h00;
         tm_q[5] <= 8'h00;
         tm_q[6] <= 8'h01;
         tm_q[7] <= 8'h01;
         tm_q[8] <= 8'h01;
         tm_q[9] <= 8'h00;
         century_rollover_flag <= 1'b0;
         system_mgmt_interrupt <= 1'b0;
      end else begin
         c_q <= c_d;
         system_mgmt_interrupt <= 1'b0;
         if (century_clr) begin
            century_rollover_flag <= 1'b0;
         end
         // Divider runs only with the documented divider code
         if (a_q[6:4] != `BRC_DIV_OK) begin
            div_q <= 15'h0000;
         end else if (tick) begin
            div_q <= div_nxt;
         end
         // UPDATE_IN_PROGRESS_FLAG leads the second boundary by the lead ticks
         if (b_q[`BRC_B_SET] || (a_q[6:4] != `BRC_DIV_OK)) begin
            a_q[`BRC_A_UIP] <= 1'b0;
         end else if (tick && (div_nxt == uip_at)) begin
            a_q[`BRC_A_UIP] <= 1'b1;
         end
         if (host_wr && !data_acc) begin
            if (acc_hi) begin
               idx_hi_q <= host_wdata[6:0];
            end else begin
               idx_lo_q <= host_wdata[6:0];
            end
         end
         if (host_wr_data && !acc_hi) begin
            if (acc_tm && !busy) begin
               tm_q[acc_idx[3:0]] <= host_wdata;
            end
            if (acc_idx == `BRC_IDX_A) begin
               a_q[6:0] <= host_wdata[6:0];
            end
            if (acc_idx == `BRC_IDX_B) begin
               b_q <= host_wdata;
            end
         end
         case (st_q)
            ST_IDLE: begin
               // Whole sequence takes at most seven clk cycles, far inside 1984 us
               if (sec_tick && a_q[`BRC_A_UIP] && !b_q[`BRC_B_SET]) begin
                  st_q <= ST_SEC;
               end
            end
            ST_SEC: begin
               tm_q[0] <= inc_nxt;
               st_q <= inc_wrap ? ST_MIN : ST_ALM;
            end
            ST_MIN: begin
               tm_q[2] <= inc_nxt;
               st_q <= inc_wrap ? ST_HR : ST_ALM;
            end
            ST_HR: begin
               st_q <= ST_ALM;
               if (b_q[`BRC_B_DSE] && (tm_q[6] == 8'h01) && (hr_b == 8'h01) &&
                   (h24 || !tm_q[4][`BRC_PM_BIT]) && (mon_b == 8'h04) &&
                   (date_b >= `BRC_DST_APR_DATE)) begin
                  tm_q[4] <= 8'h03;
               end else if (b_q[`BRC_B_DSE] && (tm_q[6] == 8'h01) && (hr_b == 8'h01) &&
                            (h24 || !tm_q[4][`BRC_PM_BIT]) && (mon_b == 8'h0A) &&
                            (date_b >= `BRC_DST_OCT_DATE) && !fall_done_q) begin
                  fall_done_q <= 1'b1;
               end else if (h24) begin
                  tm_q[4] <= inc_nxt;
                  if (inc_wrap) begin
                     st_q <= ST_DAY;
                  end
               end else begin
                  // 11 to 12 flips AM/PM; PM 11 to 12 AM carries the day
                  tm_q[4] <= {tm_q[4][`BRC_PM_BIT] ^ (inc_nxt_bin == 8'h0C),
                              inc_nxt[6:0]};
                  if ((inc_nxt_bin == 8'h0C) && tm_q[4][`BRC_PM_BIT]) begin
                     st_q <= ST_DAY;
                  end
               end
            end
            ST_DAY: begin
               tm_q[6] <= (tm_q[6] == 8'h07) ? 8'h01 : (tm_q[6] + 8'h01);
               tm_q[7] <= inc_nxt;
               fall_done_q <= 1'b0;
               st_q <= inc_wrap ? ST_MON : ST_ALM;
            end
            ST_MON: begin
               tm_q[8] <= inc_nxt;
               st_q <= inc_wrap ? ST_YR : ST_ALM;
            end
            ST_YR: begin
               tm_q[9] <= inc_nxt;
               st_q <= ST_ALM;
               if (inc_wrap) begin
                  century_rollover_flag <= 1'b1;
                  system_mgmt_interrupt <= in_working;
               end
            end
            ST_ALM: begin
               a_q[`BRC_A_UIP] <= 1'b0;
               st_q <= ST_IDLE;
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Locks are sticky; only the hard reset reopens a range
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lock0_q <= 1'b0;
         lock1_q <= 1'b0;
      end else begin
         lock0_q <= lock0_q | lock0_set;
         lock1_q <= lock1_q | lock1_set;
      end
   end

   // Read mux, registered
   always @* begin
      rd_d = ram_rdata;
      if (!data_acc) begin
         rd_d = {1'b0, acc_idx};
      end else if (acc_locked) begin
         rd_d = `BRC_LOCKED_RD;
      end else if (acc_tm) begin
         // Isolated bytes read as ones while the sequencer owns them
         rd_d = busy ? 8'hFF : tm_q[acc_idx[3:0]];
      end else if (acc_idx == `BRC_IDX_A && !acc_hi) begin
         rd_d = a_q;
      end else if (acc_idx == `BRC_IDX_B && !acc_hi) begin
         rd_d = b_q;
      end else if (acc_idx == `BRC_IDX_C && !acc_hi) begin
         rd_d = {clock_interrupt_line, c_q[2:0], 4'h0};
      end else if (acc_idx == `BRC_IDX_D && !acc_hi) begin
         rd_d = `BRC_D_VRT;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         host_rdata <= 8'h00;
         update_in_progress_flag <= 1'b0;
         clock_interrupt_line <= 1'b0;
      end else begin
         if (host_rd) begin
            host_rdata <= rd_d;
         end
         update_in_progress_flag <= a_q[`BRC_A_UIP];
         // Only internal flags drive the line; no serial-stream input exists
         clock_interrupt_line <= (c_d[2] & b_q[`BRC_B_PIE]) |
                                 (c_d[1] & b_q[`BRC_B_AIE]) |
                                 (c_d[0] & b_q[`BRC_B_UIE]);
      end
   end
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Purpose: Self-checking bench for the clock/calendar block
// Assumes: 10 MHz clock; oscillator from the far side model at half clock
// Notes: One device second (65536 clocks) is simulated, so the rollover test dominates run time
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk, rst_n, host_wr, host_rd, lock0_set, lock1_set, in_working, century_clr;
   logic osc_32k, update_in_progress_flag, clock_interrupt_line;
   logic century_rollover_flag, system_mgmt_interrupt;
   logic [1:0] host_sel;
   logic [7:0] host_wdata, host_rdata, rd_q, smi_count_q;
   int fail_count, checks_done;
   brc_top i_brc_top (.clk(clk), .rst_n(rst_n), .osc_32k(osc_32k), .host_sel(host_sel),
      .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
      .host_rdata(host_rdata), .lock0_set(lock0_set), .lock1_set(lock1_set),
      .in_working(in_working), .century_clr(century_clr),
      .update_in_progress_flag(update_in_progress_flag),
      .clock_interrupt_line(clock_interrupt_line),
      .century_rollover_flag(century_rollover_flag),
      .system_mgmt_interrupt(system_mgmt_interrupt));
   brc_sys_model i_brc_sys_model (.clk(clk), .osc_32k(osc_32k),
      .system_mgmt_interrupt(system_mgmt_interrupt), .smi_count_q(smi_count_q));
   initial begin
      clk = 1'b0;
      forever #50 clk = !clk;
   end
   task automatic test_done;
      $display("mismatches %0d, checks %0d", fail_count, checks_done);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus_wr(input logic [1:0] s, input logic [7:0] d);
      @(posedge clk);
      host_sel <= s;
      host_wr <= 1'b1;
      host_wdata <= d;
      @(posedge clk);
      host_wr <= 1'b0;
   endtask
   // Data is taken at the negedge after the loading edge, when settled
   task automatic bus_rd(input logic [1:0] s);
      @(posedge clk);
      host_sel <= s;
      host_rd <= 1'b1;
      @(posedge clk);
      host_rd <= 1'b0;
      @(negedge clk);
      rd_q = host_rdata;
   endtask
   task automatic wreg(input logic b, input logic [7:0] i, input logic [7:0] d);
      bus_wr({b, 1'b0}, i);
      bus_wr({b, 1'b1}, d);
   endtask
   task automatic rd_chk(input logic b, input logic [7:0] i, input logic [7:0] e);
      bus_wr({b, 1'b0}, i);
      bus_rd({b, 1'b1});
      chk8(rd_q, e);
   endtask
   task automatic do_reset;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
   endtask
   task automatic t_reset;
      rd_chk(1'b0, 8'h0B, 8'h02);
      rd_chk(1'b0, 8'h0A, 8'h00);
      rd_chk(1'b0, 8'h0D, 8'h80);
      rd_chk(1'b0, 8'h06, 8'h01);
      rd_chk(1'b0, 8'h09, 8'h00);
      bus_wr(2'h0, 8'h45);
      bus_rd(2'h0);
      chk8(rd_q, 8'h45);
      $display("test reset values done");
   endtask
   task automatic t_ram;
      wreg(1'b0, 8'h0E, 8'h3C);
      wreg(1'b1, 8'h7F, 8'hC3);
      wreg(1'b0, 8'h0C, 8'hFF);
      rd_chk(1'b0, 8'h0E, 8'h3C);
      rd_chk(1'b1, 8'h7F, 8'hC3);
      rd_chk(1'b0, 8'h0C, 8'h00);
      $display("test ram banks done");
   endtask
   task automatic t_lock;
      wreg(1'b0, 8'h38, 8'hA5);
      wreg(1'b1, 8'h3F, 8'h5A);
      @(posedge clk);
      lock0_set <= 1'b1;
      @(posedge clk);
      lock0_set <= 1'b0;
      wreg(1'b0, 8'h38, 8'h11);
      rd_chk(1'b0, 8'h38, 8'h00);
      rd_chk(1'b1, 8'h3F, 8'h5A);
      @(posedge clk);
      lock1_set <= 1'b1;
      @(posedge clk);
      lock1_set <= 1'b0;
      rd_chk(1'b1, 8'h3F, 8'h00);
      do_reset;
      rd_chk(1'b0, 8'h38, 8'hA5);
      $display("test range locks done");
   endtask
   // Last second of the century, all alarm fields wildcards; no leap or DST edge
   task automatic t_roll;
      logic [7:0] set_v [10] = '{8'h59, 8'hC0, 8'h59, 8'hC0, 8'h23, 8'hC0, 8'h05,
         8'h31, 8'h12, 8'h99};
      logic [7:0] exp_v [10] = '{8'h00, 8'hC0, 8'h00, 8'hC0, 8'h00, 8'hC0, 8'h06,
         8'h01, 8'h01, 8'h00};
      int n;
      in_working <= 1'b1;
      wreg(1'b0, 8'h0B, 8'hA2);
      for (int i = 0; i < 10; i++) begin
         wreg(1'b0, i[7:0], set_v[i]);
      end
      wreg(1'b0, 8'h0B, 8'h22);
      wreg(1'b0, 8'h0A, 8'h20);
      n = 0;
      while (update_in_progress_flag !== 1'b1 && n < 70000) begin
         @(posedge clk);
         n++;
      end
      chk8({7'h00, update_in_progress_flag}, 8'h01);
      rd_chk(1'b0, 8'h00, 8'h59);
      n = 0;
      while (century_rollover_flag !== 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
      end
      chk8({7'h00, century_rollover_flag}, 8'h01);
      repeat (4) @(posedge clk);
      chk8(smi_count_q, 8'h01);
      chk8({7'h00, clock_interrupt_line}, 8'h01);
      rd_chk(1'b0, 8'h0C, 8'hB0);
      repeat (2) @(posedge clk);
      chk8({7'h00, clock_interrupt_line}, 8'h00);
      for (int i = 0; i < 10; i++) begin
         rd_chk(1'b0, i[7:0], exp_v[i]);
      end
      @(posedge clk);
      century_clr <= 1'b1;
      @(posedge clk);
      century_clr <= 1'b0;
      @(negedge clk);
      chk8({7'h00, century_rollover_flag}, 8'h00);
      $display("test century rollover done");
   endtask
   initial begin
      #9000000;
      fail_count++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      test_done;
   end
   initial begin
      fail_count = 0;
      checks_done = 0;
      rst_n = 1'b0;
      host_sel = 2'h0;
      host_wr = 1'b0;
      host_rd = 1'b0;
      host_wdata = 8'h00;
      lock0_set = 1'b0;
      lock1_set = 1'b0;
      in_working = 1'b0;
      century_clr = 1'b0;
      do_reset;
      t_reset;
      t_ram;
      t_lock;
      t_roll;
      test_done;
   end
endmodule
`default_nettype wire
